//--- rtl/dsa_top.sv
// Dual-slope converter sequencer: phase control, BCD result counter,
// status flags, run/hold handling and an AHB-Lite register slave.
// Assumes the comparator inputs are synchronous to hclk and that the
// analog switches follow the phase outputs directly.
`include "dsa_defines.svh"

module dsa_top #(
  parameter logic [15:0] SI_CYC = 16'(`DSA_SI_CYC),
  parameter logic [15:0] PERIOD_CYC = 16'(`DSA_PERIOD_CYC),
  parameter logic [15:0] ZI_OR_CYC = 16'(`DSA_ZI_OR_CYC),
  parameter logic [19:0] FS_BCD = `DSA_FS_BCD
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic run_hold,
  input wire logic cmp_zero,
  input wire logic cmp_sign,
  output logic az_sw,
  output logic si_sw,
  output logic de_sw,
  output logic zi_sw,
  output logic ref_neg,
  output logic busy,
  output logic polarity,
  output logic over_range,
  output logic under_range,
  output logic [4:0] digit_select_lines,
  output logic [3:0] bcd_value_lines,
  output logic strobe_n
);
  localparam logic [5:0] TRIG_CYC = 6'(`DSA_TRIG_CYC);

  dsa_pkg::dsa_phase_t phase_q;
  dsa_pkg::dsa_phase_t phase_d;
  logic [15:0] ph_q;
  logic [15:0] cnt_q;
  logic [19:0] acc_q;
  logic [19:0] res_q;
  logic sign_q;
  logic pol_q;
  logic busy_q;
  logic over_q;
  logic under_q;
  logic ovr_pend_q;
  logic hold_q;
  logic trig_q;
  logic [5:0] hi_q;
  logic pass_q;
  logic en_q;
  logic [7:0] zi_len_q;
  logic wr_q;
  logic [7:0] waddr_q;
  logic [31:0] rdata_q;

  // ========================================================
  // Helpers
  function automatic logic [19:0] bcd_inc(input logic [19:0] v);
    logic [19:0] r;
    logic c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 5; i++) begin
      if (c) begin
        if (r[i*4 +: 4] == 4'h9) begin
          r[i*4 +: 4] = 4'h0;
        end else begin
          r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    bcd_inc = r;
  endfunction : bcd_inc

  function automatic logic [7:0] zi_clamp(input logic [7:0] v);
    if (v < `DSA_ZI_MIN) begin
      zi_clamp = `DSA_ZI_MIN;
    end else if (v > `DSA_ZI_MAX) begin
      zi_clamp = `DSA_ZI_MAX;
    end else begin
      zi_clamp = v;
    end
  endfunction : zi_clamp

  // ========================================================
  // Sequencer events
  wire in_az = (phase_q == dsa_pkg::DSA_AZ);
  wire in_si = (phase_q == dsa_pkg::DSA_SI);
  wire in_de = (phase_q == dsa_pkg::DSA_DE);
  wire in_zi = (phase_q == dsa_pkg::DSA_ZI);
  wire period_done = (cnt_q == PERIOD_CYC - 16'h0001);
  wire start_ok = en_q && (!hold_q || trig_q);
  wire go_si = in_az && period_done && start_ok;
  wire si_end = in_si && (ph_q == SI_CYC - 16'h0001);
  wire de_first = in_de && (ph_q == 16'h0000);
  wire de_cnt = in_de && !de_first;
  wire zc = de_cnt && cmp_zero;
  wire [19:0] acc_inc = bcd_inc(acc_q);
  wire ovf = de_cnt && !cmp_zero && (acc_inc == FS_BCD);
  wire [15:0] zi_len = ovr_pend_q ? ZI_OR_CYC : {8'h00, zi_len_q};
  wire zi_end = in_zi && (ph_q == zi_len - 16'h0001);
  wire phase_chg = go_si || si_end || zc || ovf || zi_end;
  wire trig_hit = hold_q && run_hold && (hi_q == TRIG_CYC);

  // ========================================================
  // Phase order
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      dsa_pkg::DSA_AZ: begin
        if (go_si) begin
          phase_d = dsa_pkg::DSA_SI;
        end
      end
      dsa_pkg::DSA_SI: begin
        if (si_end) begin
          phase_d = dsa_pkg::DSA_DE;
        end
      end
      dsa_pkg::DSA_DE: begin
        if (zc || ovf) begin
          phase_d = dsa_pkg::DSA_ZI;
        end
      end
      dsa_pkg::DSA_ZI: begin
        if (zi_end) begin
          phase_d = dsa_pkg::DSA_AZ;
        end
      end
      default: begin
        phase_d = dsa_pkg::DSA_AZ;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= dsa_pkg::DSA_AZ;
      ph_q <= 16'h0000;
    end else begin
      phase_q <= phase_d;
      ph_q <= phase_chg ? 16'h0000 : ph_q + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 16'h0000;
    end else if (go_si) begin
      cnt_q <= 16'h0000;
    end else if (!period_done) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // ========================================================
  // Result counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= 20'h00000;
    end else if (si_end) begin
      acc_q <= 20'h00000;
    end else if (de_cnt && !cmp_zero) begin
      acc_q <= acc_inc;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_q <= 20'h00000;
      pass_q <= 1'b0;
    end else begin
      if (zi_end) begin
        res_q <= acc_q;
      end
      pass_q <= zi_end;
    end
  end

  // ========================================================
  // Sign and status flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sign_q <= 1'b0;
      pol_q <= 1'b0;
    end else if (si_end) begin
      sign_q <= cmp_sign;
      pol_q <= cmp_sign;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q <= 1'b0;
    end else if (go_si) begin
      busy_q <= 1'b1;
    end else if (zc || (zi_end && ovr_pend_q)) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      over_q <= 1'b0;
      ovr_pend_q <= 1'b0;
    end else begin
      if (zi_end && ovr_pend_q) begin
        over_q <= 1'b1;
      end else if (si_end) begin
        over_q <= 1'b0;
      end
      if (ovf) begin
        ovr_pend_q <= 1'b1;
      end else if (zi_end) begin
        ovr_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      under_q <= 1'b0;
    end else if (zc && (acc_q <= `DSA_UR_BCD)) begin
      under_q <= 1'b1;
    end else if (go_si) begin
      under_q <= 1'b0;
    end
  end

  // ========================================================
  // Run and hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_q <= 1'b0;
    end else if (zi_end) begin
      hold_q <= !run_hold;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_q <= 6'h00;
      trig_q <= 1'b0;
    end else begin
      if (!hold_q || !run_hold) begin
        hi_q <= 6'h00;
      end else if (hi_q != TRIG_CYC) begin
        hi_q <= hi_q + 6'h01;
      end
      if (trig_hit) begin
        trig_q <= 1'b1;
      end else if (go_si || !hold_q) begin
        trig_q <= 1'b0;
      end
    end
  end

  // ========================================================
  // Digit scanner
  dsa_scan_if u_if ();

  assign u_if.start_pass = pass_q;
  assign u_if.de_start = si_end;
  assign u_if.ovr = over_q;
  assign u_if.value = res_q;

  dsa_scan u_scan (
    .hclk(hclk),
    .hresetn(hresetn),
    .sif(u_if)
  );

  // ========================================================
  // AHB-Lite slave, zero wait states
  wire ap = hsel && htrans[1] && hready;
  wire [7:0] ra = haddr[7:0];
  logic [31:0] rmux;

  always_comb begin
    rmux = 32'h00000000;
    case (ra)
      `DSA_OFF_CTRL: rmux[`DSA_CTRL_EN] = en_q;
      `DSA_OFF_ZILEN: rmux[7:0] = zi_len_q;
      `DSA_OFF_STATUS: begin
        rmux[`DSA_ST_BUSY] = busy_q;
        rmux[`DSA_ST_POL] = pol_q;
        rmux[`DSA_ST_OVER] = over_q;
        rmux[`DSA_ST_UNDER] = under_q;
        rmux[`DSA_ST_PH_LO +: 2] = phase_q;
        rmux[`DSA_ST_HOLD] = hold_q;
      end
      `DSA_OFF_RESULT: rmux[19:0] = res_q;
      default: rmux = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
      rdata_q <= 32'h00000000;
    end else begin
      wr_q <= ap && hwrite;
      if (ap) begin
        waddr_q <= ra;
      end
      if (ap && !hwrite) begin
        rdata_q <= rmux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= `DSA_CTRL_RST;
      zi_len_q <= `DSA_ZILEN_RST;
    end else if (wr_q) begin
      if (waddr_q == `DSA_OFF_CTRL) begin
        en_q <= hwdata[`DSA_CTRL_EN];
      end
      if (waddr_q == `DSA_OFF_ZILEN) begin
        zi_len_q <= zi_clamp(hwdata[7:0]);
      end
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ========================================================
  // Analog switch controls and outputs
  // auto-zero switches
  assign az_sw = in_az;
  assign si_sw = in_si;
  assign de_sw = in_de;
  assign ref_neg = sign_q;
  assign zi_sw = in_zi;
  assign busy = busy_q;
  assign polarity = pol_q;
  assign over_range = over_q;
  assign under_range = under_q;
  assign digit_select_lines = u_if.dsel;
  assign bcd_value_lines = u_if.bcd;
  // The latch pulse must be half a clock wide, so it is gated by
  // the low half of hclk; it falls mid-cycle and rises on the edge.
  assign strobe_n = ~(u_if.stb & ~hclk);
endmodule : dsa_top

//--- rtl/dsa_defines.svh
// Constants of the dual-slope converter sequencer: offsets, fields,
// reset values and timing counts.
// Assumes a 100 MHz hclk; included by bare name.
`ifndef DSA_DEFINES_SVH
`define DSA_DEFINES_SVH

// ==========================================================
// Timing
`define DSA_CLK_NS 10
`define DSA_TRIG_NS 300
`define DSA_TRIG_CYC ((`DSA_TRIG_NS + `DSA_CLK_NS - 1) / `DSA_CLK_NS)
`define DSA_SI_CYC 10001
`define DSA_PERIOD_CYC 40002
`define DSA_ZI_OR_CYC 6200
`define DSA_ZI_MIN 8'h64
`define DSA_ZI_MAX 8'hC8
`define DSA_DIG_LAST 8'hC7
`define DSA_STB_POS 8'h65
`define DSA_FS_BCD 20'h20000
`define DSA_UR_BCD 20'h01800

// ==========================================================
// Register offsets
`define DSA_OFF_CTRL 8'h00
`define DSA_OFF_ZILEN 8'h04
`define DSA_OFF_STATUS 8'h08
`define DSA_OFF_RESULT 8'h0C

// ==========================================================
// Fields and reset values
`define DSA_CTRL_EN 0
`define DSA_ST_BUSY 0
`define DSA_ST_POL 1
`define DSA_ST_OVER 2
`define DSA_ST_UNDER 3
`define DSA_ST_PH_LO 4
`define DSA_ST_HOLD 6
`define DSA_CTRL_RST 1'b1
`define DSA_ZILEN_RST 8'h96

`endif

//--- rtl/dsa_pkg.sv
// Types shared by the converter sequencer and its digit scanner.
// Assumes nothing beyond a SystemVerilog tool.
package dsa_pkg;
  typedef enum logic [1:0] {
    DSA_AZ,
    DSA_SI,
    DSA_DE,
    DSA_ZI
  } dsa_phase_t;
  typedef logic [3:0] dsa_digit_t;
  typedef dsa_digit_t [4:0] dsa_val_t;
endpackage : dsa_pkg

//--- rtl/dsa_scan_if.sv
// Carrier between the sequencer core and the digit scanner.
// Assumes both ends run on the same hclk.
interface dsa_scan_if;
  logic start_pass;
  logic de_start;
  logic ovr;
  dsa_pkg::dsa_val_t value;
  logic [4:0] dsel;
  logic [3:0] bcd;
  logic stb;
  modport ctl (
    output start_pass,
    output de_start,
    output ovr,
    output value,
    input dsel,
    input bcd,
    input stb
  );
  modport scan (
    input start_pass,
    input de_start,
    input ovr,
    input value,
    output dsel,
    output bcd,
    output stb
  );
endinterface : dsa_scan_if

//--- rtl/dsa_scan.sv
// Digit scanner: one strobed pass after each finished cycle, then
// continuous scanning, blanked after an over-range.
// Assumes start_pass and de_start are one-cycle pulses on hclk.
`include "dsa_defines.svh"

module dsa_scan (
  input wire logic hclk,
  input wire logic hresetn,
  dsa_scan_if.scan sif
);
  logic [2:0] dig_q;
  logic [7:0] s_q;
  logic first_q;
  logic pass_q;
  logic blank_q;
  logic [4:0] dsel_q;
  logic [3:0] bcd_q;
  logic stb_q;

  function automatic logic [4:0] onehot(input logic [2:0] d);
    onehot = 5'h01 << d;
  endfunction : onehot

  wire [7:0] last = first_q ? `DSA_ZI_MAX : `DSA_DIG_LAST;
  wire slot_end = (s_q == last);

  // ========================================================
  // Scan sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dig_q <= 3'h4;
      s_q <= 8'h00;
      first_q <= 1'b0;
      pass_q <= 1'b0;
      blank_q <= 1'b0;
    end else if (sif.start_pass) begin
      dig_q <= 3'h4;
      s_q <= 8'h00;
      first_q <= 1'b1;
      pass_q <= 1'b1;
      blank_q <= 1'b0;
    end else if (sif.de_start && blank_q) begin
      dig_q <= 3'h4;
      s_q <= 8'h00;
      blank_q <= 1'b0;
    end else if (!blank_q) begin
      if (slot_end) begin
        s_q <= 8'h00;
        first_q <= 1'b0;
        if (dig_q == 3'h0) begin
          dig_q <= 3'h4;
          pass_q <= 1'b0;
          blank_q <= pass_q && sif.ovr;
        end else begin
          dig_q <= dig_q - 3'h1;
        end
      end else begin
        s_q <= s_q + 8'h01;
      end
    end
  end

  // ========================================================
  // Registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dsel_q <= 5'h00;
      bcd_q <= 4'h0;
      stb_q <= 1'b0;
    end else begin
      dsel_q <= blank_q ? 5'h00 : onehot(dig_q);
      bcd_q <= blank_q ? 4'h0 : sif.value[dig_q];
      stb_q <= pass_q && !blank_q && (s_q == `DSA_STB_POS);
    end
  end

  assign sif.dsel = dsel_q;
  assign sif.bcd = bcd_q;
  assign sif.stb = stb_q;
endmodule : dsa_scan

//--- tb/dsa_top_asserts.sv
// Pin-level checks on the converter sequencer top.
// Assumes it is bound into dsa_top and every pin lives on hclk.
module dsa_top_asserts #(
  parameter logic [15:0] SI_CYC = 16'h0015,
  parameter logic [15:0] PERIOD_CYC = 16'h0078
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run_hold,
  input wire logic az_sw,
  input wire logic si_sw,
  input wire logic de_sw,
  input wire logic zi_sw,
  input wire logic ref_neg,
  input wire logic busy,
  input wire logic polarity,
  input wire logic over_range,
  input wire logic under_range,
  input wire logic [4:0] digit_select_lines,
  input wire logic strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Helper counters
  logic [15:0] si_n_q;
  logic [15:0] per_q;
  logic [8:0] dw_q;
  logic [4:0] ds_q;
  logic si_q;
  logic seen_q;
  logic run_ok_q;
  logic zi_q;
  logic zf1_q;
  logic zf2_q;
  wire logic si_up = si_sw & ~si_q;
  wire logic ds_new = digit_select_lines != ds_q;

  // The period check only counts spans with run_hold high throughout.
  // A new strobed pass may restart the top digit while its line is
  // already high, so the slot count also restarts two clocks after the
  // zero-integrate phase ends, when the restarted slot reaches the pins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      si_q <= 1'b0;
      seen_q <= 1'b0;
      run_ok_q <= 1'b0;
      si_n_q <= 16'h0000;
      per_q <= 16'h0000;
      ds_q <= 5'h00;
      dw_q <= 9'h000;
      zi_q <= 1'b0;
      zf1_q <= 1'b0;
      zf2_q <= 1'b0;
    end else begin
      zi_q <= zi_sw;
      zf1_q <= zi_q & ~zi_sw;
      zf2_q <= zf1_q;
      si_q <= si_sw;
      seen_q <= seen_q | si_up;
      run_ok_q <= si_up ? run_hold : (run_ok_q & run_hold);
      si_n_q <= si_sw ? si_n_q + 16'h0001 : 16'h0000;
      per_q <= si_up ? 16'h0001 : per_q + 16'h0001;
      ds_q <= digit_select_lines;
      dw_q <= (ds_new || zf2_q) ? 9'h001 : dw_q + 9'h001;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_busy_end;
    $fell(busy);
  endsequence
  sequence s_de_entry;
    $rose(de_sw);
  endsequence

  // ==========================================================
  // Properties
  a_phase_order: assert property (
    ($rose(si_sw) |-> $past(az_sw)) and ($rose(de_sw) |-> $past(si_sw))
    and ($rose(zi_sw) |-> $past(de_sw)) and ($rose(az_sw) |-> $past(zi_sw)))
    else $error("phase order broken");
  a_si_length: assert property (
    $fell(si_sw) |-> si_n_q == SI_CYC) else $error("integrate length");
  a_busy_start: assert property (
    $rose(si_sw) |-> $rose(busy)) else $error("busy not at integrate");
  a_cycle_period: assert property (
    si_up && seen_q && run_ok_q && run_hold |-> per_q == PERIOD_CYC)
    else $error("cycle period wrong");
  a_over_set: assert property (
    $rose(over_range) |-> s_busy_end) else $error("over flag timing");
  a_over_clear: assert property (
    s_de_entry |-> !over_range) else $error("over flag not cleared");
  a_under_flag: assert property (
    ($rose(under_range) |-> s_busy_end) and ($rose(si_sw) |-> !under_range))
    else $error("under flag timing");
  a_sign_update: assert property (
    $changed(polarity) |-> s_de_entry) else $error("polarity moved");
  a_ref_sign: assert property (
    de_sw |-> ref_neg == polarity) else $error("reference sign");
  // The latch pulse lies in the low half of hclk, so it is seen at the
  // rising edge that ends it; at the falling edge it is not yet low.
  a_strobe_mid: assert property (
    !strobe_n |-> dw_q == 9'h065)
    else $error("strobe not mid digit");
  a_digit_step: assert property (
    ds_new && ds_q != 5'h00 && digit_select_lines != 5'h00
    && digit_select_lines != 5'h10 |-> digit_select_lines == (ds_q >> 1)
    && (dw_q == 9'h0C8 || (ds_q == 5'h10 && dw_q == 9'h0C9)))
    else $error("digit step wrong");
endmodule : dsa_top_asserts

//--- tb/dsa_fe_model.sv
// Far-side model: integrator comparator and a digit latch.
// Assumes one-hot phase and digit lines synchronous to hclk.
module dsa_fe_model (
  input wire logic hclk,
  input wire logic si_sw,
  input wire logic de_sw,
  input wire logic busy,
  input wire logic strobe_n,
  input wire logic [4:0] dsel,
  input wire logic [3:0] bcd,
  input wire logic [15:0] count,
  input wire logic sign,
  output logic cmp_zero,
  output logic cmp_sign,
  output dsa_pkg::dsa_val_t got,
  output logic [7:0] nstb,
  output logic [15:0] bsum
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] de_n;
  logic [15:0] bn;

  initial begin
    got = '0;
    nstb = 8'h00;
    de_n = 16'h0000;
    bn = 16'h0000;
    bsum = 16'h0000;
  end

  // busy-gated clock count
  // The idle first de-integrate clock and the detecting clock also ride
  // on busy, so the total is the integrate length plus result plus two.
  always @(posedge hclk) begin
    if (busy) begin
      bn <= bn + 16'h0001;
    end else if (bn != 16'h0000) begin
      bsum <= bn;
      bn <= 16'h0000;
    end
  end

  always @(posedge hclk) begin
    de_n <= de_sw ? de_n + 16'h0001 : 16'h0000;
  end

  assign cmp_zero = de_sw && (de_n > count);
  // Sign is only meaningful while integrating; otherwise inverted.
  assign cmp_sign = si_sw ? sign : ~sign;

  // capture on strobe edge
  // Taking the falling edge of the pulse itself avoids racing the
  // gated clock that forms it.
  always @(negedge strobe_n) begin
    for (int i = 0; i < 5; i++) begin
      if (dsel[i]) begin
        got[i] <= bcd;
      end
    end
    nstb <= nstb + 8'h01;
  end
endmodule : dsa_fe_model

//--- tb/dsa_top_tb.sv
// Bench for the converter sequencer: registers, run and hold,
// digit pass and range flags.
// Assumes the front-end model drives the comparator pins.
module dsa_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] SI_CYC = 16'h0015;
  localparam logic [15:0] PERIOD_CYC = 16'h04B0;
  logic hclk, hresetn, hsel, hwrite, run_hold, sign, si_prev;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] count;
  wire logic hready, cmp_zero, cmp_sign, az_sw, si_sw, de_sw, zi_sw;
  wire logic ref_neg, busy, polarity, over_range, under_range, strobe_n;
  wire logic hresp;
  wire logic [15:0] bsum;
  wire logic [31:0] hrdata;
  wire logic [4:0] dsel;
  wire logic [3:0] bcd;
  wire dsa_pkg::dsa_val_t got;
  wire logic [7:0] nstb;
  int mismatches = 0;
  int cmp_count = 0;
  int rises = 0;

  dsa_top #(.SI_CYC(SI_CYC), .PERIOD_CYC(PERIOD_CYC),
    .ZI_OR_CYC(16'h000F), .FS_BCD(20'h00050)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .run_hold(run_hold), .cmp_zero(cmp_zero), .cmp_sign(cmp_sign),
    .az_sw(az_sw), .si_sw(si_sw), .de_sw(de_sw), .zi_sw(zi_sw),
    .ref_neg(ref_neg), .busy(busy), .polarity(polarity),
    .over_range(over_range), .under_range(under_range),
    .digit_select_lines(dsel), .bcd_value_lines(bcd), .strobe_n(strobe_n));

  dsa_fe_model fe_u (.hclk(hclk), .si_sw(si_sw), .de_sw(de_sw),
    .busy(busy), .strobe_n(strobe_n), .dsel(dsel), .bcd(bcd),
    .count(count), .sign(sign), .cmp_zero(cmp_zero),
    .cmp_sign(cmp_sign), .got(got), .nstb(nstb), .bsum(bsum));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    si_prev <= si_sw;
    if (si_sw && !si_prev) rises <= rises + 1;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] act);
    cmp_count++;
    if (act !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", what, exp, act);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(what, exp, r);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rd_chk

  task automatic wait_ge(input logic strobes, input int n);
    int i;
    i = 0;
    while (((strobes ? int'(nstb) : rises) < n) && i < 9000) begin
      @(posedge hclk);
      i++;
    end
    chk("wait", 32'h1, {31'h0, i < 9000});
  endtask : wait_ge

  task automatic tally_and_finish();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (30000) @(posedge hclk);
    mismatches++;
    tally_and_finish();
  end

  // ==========================================================
  // Sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    run_hold = 1'b1;
    sign = 1'b1;
    count = 16'h0025;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("ctrl", 8'h00, 32'h1);
    rd_chk("zilen", 8'h04, 32'h96);
    rd_chk("status", 8'h08, 32'h0);
    ahb(1'b1, 8'h0C, 32'h1234, rd);
    rd_chk("result", 8'h0C, 32'h0);
    rd_chk("unmapped", 8'h10, 32'h0);
    ahb(1'b1, 8'h04, 32'hFF, rd);
    rd_chk("zi_hi", 8'h04, 32'hC8);
    ahb(1'b1, 8'h04, 32'h05, rd);
    rd_chk("zi_lo", 8'h04, 32'h64);
    wait_ge(1'b0, 1);
    wait_ge(1'b1, 5);
    chk("digits", 32'h37, 32'(got));
    chk("busy_len", 32'h3C, 32'(bsum));
    chk("polarity", 32'h1, {31'h0, polarity});
    chk("under", 32'h1, {31'h0, under_range});
    rd_chk("result", 8'h0C, 32'h37);
    count <= 16'h000C;
    sign <= 1'b0;
    wait_ge(1'b0, 2);
    run_hold <= 1'b0;
    repeat (3) @(posedge hclk);
    run_hold <= 1'b1;
    repeat (40) @(posedge hclk);
    run_hold <= 1'b0;
    wait_ge(1'b1, 10);
    chk("digits", 32'h12, 32'(got));
    rd_chk("status", 8'h08, 32'h48);
    repeat (2400) @(posedge hclk);
    chk("held", 32'h2, 32'(rises));
    chk("strobes", 32'hA, 32'(nstb));
    chk("scan", 32'h1, {31'h0, dsel != 5'h00});
    count <= 16'h003C;
    sign <= 1'b1;
    run_hold <= 1'b1;
    repeat (40) @(posedge hclk);
    run_hold <= 1'b0;
    wait_ge(1'b0, 3);
    wait_ge(1'b1, 15);
    repeat (150) @(posedge hclk);
    chk("over", 32'h1, {31'h0, over_range});
    chk("busy", 32'h0, {31'h0, busy});
    chk("blank", 32'h0, 32'(dsel));
    count <= 16'h0005;
    run_hold <= 1'b1;
    wait_ge(1'b0, 4);
    repeat (23) @(posedge hclk);
    chk("over", 32'h0, {31'h0, over_range});
    chk("under", 32'h0, {31'h0, under_range});
    wait_ge(1'b1, 20);
    chk("digits", 32'h05, 32'(got));
    rd_chk("result", 8'h0C, 32'h05);
    tally_and_finish();
  end
endmodule : dsa_top_tb

bind dsa_top dsa_top_asserts #(.SI_CYC(SI_CYC), .PERIOD_CYC(PERIOD_CYC))
  chk_u (.hclk(hclk), .hresetn(hresetn), .run_hold(run_hold),
  .az_sw(az_sw), .si_sw(si_sw), .de_sw(de_sw), .zi_sw(zi_sw),
  .ref_neg(ref_neg), .busy(busy), .polarity(polarity),
  .over_range(over_range), .under_range(under_range),
  .digit_select_lines(digit_select_lines), .strobe_n(strobe_n));
